// ### pkg/acwd_pkg.sv
// constants and types shared by the converter control word decoder
`default_nettype none

package acwd_pkg;

    // serial frame layout
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned DATA_BITS  = 14;
    localparam int unsigned CNT_W      = 5;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h10;
    localparam logic [1:0] ADDR_NONE    = 2'h0;
    localparam logic [1:0] ADDR_TEST    = 2'h1;
    localparam logic [1:0] ADDR_CALIB   = 2'h2;
    localparam logic [1:0] ADDR_CONTROL = 2'h3;

    // control word field positions
    localparam int unsigned BIT_ARRANGE    = 13;
    localparam int unsigned BIT_CHAN_HI    = 12;
    localparam int unsigned BIT_CHAN_LO    = 10;
    localparam int unsigned BIT_PMGT_HI    = 9;
    localparam int unsigned BIT_PMGT_LO    = 8;
    localparam int unsigned BIT_RDSEL_HI   = 7;
    localparam int unsigned BIT_RDSEL_LO   = 6;
    localparam int unsigned BIT_IF_MODE    = 5;
    localparam int unsigned BIT_CONV_START = 4;
    localparam int unsigned BIT_CAL_FAMILY = 3;
    localparam int unsigned BIT_CALSEL_HI  = 2;
    localparam int unsigned BIT_CALSEL_LO  = 1;
    localparam int unsigned BIT_CAL_START  = 0;

    // reset value of the whole word
    localparam logic [DATA_BITS-1:0] CTRL_RESET = 14'h0000;

    // read source codes and one-hot selects
    localparam logic [1:0] RD_CONV_DATA = 2'h0;
    localparam logic [1:0] RD_TEST      = 2'h1;
    localparam logic [1:0] RD_CALIB     = 2'h2;
    localparam logic [1:0] RD_STATUS    = 2'h3;

    // calibration selection codes
    localparam logic [1:0] CAL_FULL      = 2'h0;
    localparam logic [1:0] CAL_GAIN_OFFS = 2'h1;
    localparam logic [1:0] CAL_OFFS_ONLY = 2'h2;
    localparam logic [1:0] CAL_GAIN_ONLY = 2'h3;

    // calibration step mask {dac, gain, offset}
    localparam logic [2:0] STEPS_FULL      = 3'h7;
    localparam logic [2:0] STEPS_GAIN_OFFS = 3'h3;
    localparam logic [2:0] STEPS_OFFS      = 3'h1;
    localparam logic [2:0] STEPS_GAIN      = 3'h2;

    // coefficient bank one-hot {gain, offset, gain+offset, all ten}
    localparam logic [3:0] COEF_ALL_TEN    = 4'h1;
    localparam logic [3:0] COEF_GAIN_OFFS  = 4'h2;
    localparam logic [3:0] COEF_OFFS       = 4'h4;
    localparam logic [3:0] COEF_GAIN       = 4'h8;

    // analog input number meaning ground on the negative side
    localparam logic [3:0] INPUT_GROUND = 4'h0;

    typedef enum logic [2:0] {
        FR_IDLE  = 3'h1,
        FR_SHIFT = 3'h2,
        FR_HOLD  = 3'h4
    } acwd_frame_state_t;

endpackage : acwd_pkg

`default_nettype wire

// ### design/acwd_decoder.sv
// converter control word: serial frame capture, storage and decoding
`default_nettype none

module acwd_decoder
(
    // clock and reset
    input  wire logic                       sys_clk_in,
    input  wire logic                       rst_n_in,
    // serial link from host
    input  wire logic                       link_sclk_in,
    input  wire logic                       link_frame_n_in,
    input  wire logic                       link_din_in,
    // completion indications from converter core
    input  wire logic                       conv_done_in,
    input  wire logic                       cal_done_in,
    // input arrangement and channel
    output logic                            input_arrangement_sel_out,
    output logic [2:0]                      chan_sel_out,
    output logic [3:0]                      pos_input_out,
    output logic [3:0]                      neg_input_out,
    // power management and read selection
    output logic [1:0]                      power_mgmt_out,
    output logic [1:0]                      read_sel_out,
    output logic [3:0]                      read_src_out,
    // interface mode
    output logic                            iface_mode1_out,
    // conversion
    output logic                            soft_convert_start_out,
    output logic                            conv_start_pulse_out,
    // calibration
    output logic                            cal_family_sel_out,
    output logic [1:0]                      cal_sel_out,
    output logic                            cal_start_out,
    output logic                            cal_start_pulse_out,
    output logic [2:0]                      cal_steps_out,
    output logic [3:0]                      coef_sel_out,
    // write strobes for the other write targets
    output logic                            test_write_out,
    output logic                            calib_write_out,
    output logic [acwd_pkg::DATA_BITS-1:0]  write_data_out
);
    import acwd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode functions

    // positive side input number 1..8
    function automatic logic [3:0] pos_input(input logic [2:0] code);
        logic [3:0] base;
        base = {1'b0, code[1:0], 1'b0} + 4'h1;
        pos_input = code[2] ? base + 4'h1 : base;
    endfunction : pos_input

    // negative side input number, ground in single-ended mode
    function automatic logic [3:0] neg_input(input logic sgl, input logic [2:0] code);
        logic [3:0] base;
        base = {1'b0, code[1:0], 1'b0} + 4'h1;
        if (sgl) begin
            neg_input = INPUT_GROUND;
        end else if (code[2]) begin
            neg_input = base;
        end else begin
            neg_input = base + 4'h1;
        end
    endfunction : neg_input

    // calibration steps, same sequence for both families
    function automatic logic [2:0] cal_steps(input logic [1:0] sel);
        unique case (sel)
            CAL_FULL:      cal_steps = STEPS_FULL;
            CAL_GAIN_OFFS: cal_steps = STEPS_GAIN_OFFS;
            CAL_OFFS_ONLY: cal_steps = STEPS_OFFS;
            CAL_GAIN_ONLY: cal_steps = STEPS_GAIN;
        endcase
    endfunction : cal_steps

    // coefficient bank addressed while no calibration is requested
    function automatic logic [3:0] coef_sel(input logic [1:0] sel);
        unique case (sel)
            CAL_FULL:      coef_sel = COEF_ALL_TEN;
            CAL_GAIN_OFFS: coef_sel = COEF_GAIN_OFFS;
            CAL_OFFS_ONLY: coef_sel = COEF_OFFS;
            CAL_GAIN_ONLY: coef_sel = COEF_GAIN;
        endcase
    endfunction : coef_sel

    function automatic logic [3:0] read_src(input logic [1:0] sel);
        unique case (sel)
            RD_CONV_DATA: read_src = 4'h1;
            RD_TEST:      read_src = 4'h2;
            RD_CALIB:     read_src = 4'h4;
            RD_STATUS:    read_src = 4'h8;
        endcase
    endfunction : read_src

    ////////////////////////////////////////////////////////////////////////////
    // link synchronisers: the host clock is asynchronous to ours

    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic frame_n_s1;
    logic frame_n_s2;
    logic din_s1;
    logic din_s2;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            // idle level of the host clock, so no edge is seen after reset
            sclk_s1    <= 1'b1;
            sclk_s2    <= 1'b1;
            sclk_s3    <= 1'b1;
            frame_n_s1 <= 1'b1;
            frame_n_s2 <= 1'b1;
            din_s1     <= 1'b0;
            din_s2     <= 1'b0;
        end else begin
            sclk_s1    <= link_sclk_in;
            sclk_s2    <= sclk_s1;
            sclk_s3    <= sclk_s2;
            frame_n_s1 <= link_frame_n_in;
            frame_n_s2 <= frame_n_s1;
            din_s1     <= link_din_in;
            din_s2     <= din_s1;
        end
    end

    // data is taken on the falling edge; din is stable then by half a period
    logic sclk_fall;
    assign sclk_fall = sclk_s3 & ~sclk_s2;

    ////////////////////////////////////////////////////////////////////////////
    // frame capture

    acwd_frame_state_t      state;
    acwd_frame_state_t      next_state;
    logic [CNT_W-1:0]       bit_cnt;
    logic [FRAME_BITS-1:0]  shift_reg;
    logic                   word_ready;
    logic                   frame_end;
    logic                   ctrl_wr;
    logic                   wrote_ctrl;

    always_comb begin
        next_state = state;
        word_ready = 1'b0;
        unique case (state)
            FR_IDLE: begin
                if (!frame_n_s2) begin
                    next_state = FR_SHIFT;
                end
            end
            FR_SHIFT: begin
                // a frame cut short is dropped whole
                if (frame_n_s2) begin
                    next_state = FR_IDLE;
                end else if (bit_cnt == FRAME_LAST) begin
                    word_ready = 1'b1;
                    next_state = FR_HOLD;
                end
            end
            FR_HOLD: begin
                // extra clocks past sixteen are ignored
                if (frame_n_s2) begin
                    next_state = FR_IDLE;
                end
            end
            default: next_state = FR_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state <= FR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            bit_cnt   <= '0;
            shift_reg <= '0;
        end else if (state != FR_SHIFT) begin
            bit_cnt   <= '0;
        end else if (sclk_fall && !frame_n_s2 && bit_cnt != FRAME_LAST) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], din_s2};
            bit_cnt   <= bit_cnt + 5'h01;
        end
    end

    // frame end closes a read cycle as well as a write
    assign frame_end = (state != FR_IDLE) && frame_n_s2;
    assign ctrl_wr   = word_ready &&
                       shift_reg[FRAME_BITS-1 -: 2] == ADDR_CONTROL;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wrote_ctrl <= 1'b0;
        end else if (ctrl_wr) begin
            wrote_ctrl <= 1'b1;
        end else if (state == FR_IDLE) begin
            wrote_ctrl <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control word: write-only, no read path exists

    logic [DATA_BITS-1:0] ctrl;
    logic [DATA_BITS-1:0] next_ctrl;

    always_comb begin
        next_ctrl = ctrl;
        // a frame that itself wrote the word keeps the written mode bit
        if (frame_end && !wrote_ctrl) begin
            next_ctrl[BIT_IF_MODE] = 1'b0;
        end
        if (conv_done_in) begin
            next_ctrl[BIT_CONV_START] = 1'b0;
        end
        if (cal_done_in) begin
            next_ctrl[BIT_CAL_START] = 1'b0;
        end
        // a write lands after the clears so it wins the same cycle
        if (ctrl_wr) begin
            next_ctrl = shift_reg[DATA_BITS-1:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded outputs, registered from the next word so they track ctrl

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            input_arrangement_sel_out <= 1'b0;
            chan_sel_out              <= 3'h0;
            pos_input_out             <= 4'h1;
            neg_input_out             <= 4'h2;
        end else begin
            input_arrangement_sel_out <= next_ctrl[BIT_ARRANGE];
            chan_sel_out              <= next_ctrl[BIT_CHAN_HI:BIT_CHAN_LO];
            pos_input_out             <= pos_input(next_ctrl[BIT_CHAN_HI:BIT_CHAN_LO]);
            neg_input_out             <= neg_input(next_ctrl[BIT_ARRANGE],
                                                   next_ctrl[BIT_CHAN_HI:BIT_CHAN_LO]);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            power_mgmt_out  <= 2'h0;
            read_sel_out    <= RD_CONV_DATA;
            read_src_out    <= 4'h1;
            iface_mode1_out <= 1'b0;
        end else begin
            power_mgmt_out  <= next_ctrl[BIT_PMGT_HI:BIT_PMGT_LO];
            read_sel_out    <= next_ctrl[BIT_RDSEL_HI:BIT_RDSEL_LO];
            read_src_out    <= read_src(next_ctrl[BIT_RDSEL_HI:BIT_RDSEL_LO]);
            iface_mode1_out <= next_ctrl[BIT_IF_MODE];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            soft_convert_start_out <= 1'b0;
            conv_start_pulse_out   <= 1'b0;
        end else begin
            soft_convert_start_out <= next_ctrl[BIT_CONV_START];
            conv_start_pulse_out   <= ctrl_wr && shift_reg[BIT_CONV_START];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cal_family_sel_out  <= 1'b0;
            cal_sel_out         <= 2'h0;
            cal_start_out       <= 1'b0;
            cal_start_pulse_out <= 1'b0;
            cal_steps_out       <= 3'h0;
            coef_sel_out        <= COEF_ALL_TEN;
        end else begin
            cal_family_sel_out  <= next_ctrl[BIT_CAL_FAMILY];
            cal_sel_out         <= next_ctrl[BIT_CALSEL_HI:BIT_CALSEL_LO];
            cal_start_out       <= next_ctrl[BIT_CAL_START];
            cal_start_pulse_out <= ctrl_wr && shift_reg[BIT_CAL_START];
            // steps shown only while a calibration is requested
            cal_steps_out       <= next_ctrl[BIT_CAL_START] ?
                                   cal_steps(next_ctrl[BIT_CALSEL_HI:BIT_CALSEL_LO]) :
                                   3'h0;
            // coefficient bank shown only while no calibration is requested
            coef_sel_out        <= next_ctrl[BIT_CAL_START] ? 4'h0 :
                                   coef_sel(next_ctrl[BIT_CALSEL_HI:BIT_CALSEL_LO]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strobes for the test and calibration write targets; address 00 drops

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            test_write_out  <= 1'b0;
            calib_write_out <= 1'b0;
            write_data_out  <= '0;
        end else begin
            test_write_out  <= word_ready &&
                               shift_reg[FRAME_BITS-1 -: 2] == ADDR_TEST;
            calib_write_out <= word_ready &&
                               shift_reg[FRAME_BITS-1 -: 2] == ADDR_CALIB;
            if (word_ready && shift_reg[FRAME_BITS-1 -: 2] != ADDR_NONE) begin
                write_data_out <= shift_reg[DATA_BITS-1:0];
            end
        end
    end

endmodule : acwd_decoder

`default_nettype wire

// ### testbench/acwd_decoder_assertions.sv
// checker for the converter control word decoder
`default_nettype none
module acwd_decoder_chk
    import acwd_pkg::*;
(
    // clock, reset and inputs
    input wire logic       sys_clk_in,
    input wire logic       rst_n_in,
    input wire logic       link_frame_n_in,
    input wire logic       conv_done_in,
    input wire logic       cal_done_in,
    // decoded outputs
    input wire logic       input_arrangement_sel_out,
    input wire logic [2:0] chan_sel_out,
    input wire logic [3:0] pos_input_out,
    input wire logic [3:0] neg_input_out,
    input wire logic [1:0] power_mgmt_out,
    input wire logic [1:0] read_sel_out,
    input wire logic [3:0] read_src_out,
    input wire logic       soft_convert_start_out,
    input wire logic       conv_start_pulse_out,
    input wire logic [1:0] cal_sel_out,
    input wire logic       cal_start_out,
    input wire logic       cal_start_pulse_out,
    input wire logic [2:0] cal_steps_out,
    input wire logic [3:0] coef_sel_out,
    input wire logic       test_write_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] idle_cnt;
    logic [3:0] base;
    assign base = {1'b0, chan_sel_out[1:0], 1'b0} + 4'h1;
    // 15 quiet cycles outlast the link synchronisers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || !link_frame_n_in) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hF) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end
    ////////////////////////////////////////
    a_reset_clear: assert property (disable iff (1'b0)
        !rst_n_in |=> {input_arrangement_sel_out, chan_sel_out, power_mgmt_out, read_sel_out,
        soft_convert_start_out, cal_sel_out, cal_start_out} == 12'h000
        && pos_input_out == 4'h1 && neg_input_out == 4'h2 && coef_sel_out == COEF_ALL_TEN)
        else $error("word not cleared by reset");
    a_read_src_map: assert property (
        read_src_out == 4'h1 << read_sel_out) else $error("read source decode wrong");
    a_pos_decode: assert property (
        pos_input_out == base + {3'h0, chan_sel_out[2]}) else $error("positive input wrong");
    a_neg_decode: assert property (
        neg_input_out == (input_arrangement_sel_out ? INPUT_GROUND
        : (chan_sel_out[2] ? base : base + 4'h1))) else $error("negative input wrong");
    a_conv_done_clr: assert property (
        conv_done_in |=> !soft_convert_start_out || conv_start_pulse_out)
        else $error("conversion start not cleared");
    a_conv_pulse_set: assert property (
        conv_start_pulse_out |-> soft_convert_start_out ##1 !conv_start_pulse_out)
        else $error("conversion pulse wrong");
    a_cal_done_clr: assert property (
        cal_done_in |=> !cal_start_out || cal_start_pulse_out)
        else $error("calibration start not cleared");
    a_cal_pulse_set: assert property (
        cal_start_pulse_out |-> cal_start_out ##1 !cal_start_pulse_out)
        else $error("calibration pulse wrong");
    a_steps_decode: assert property (
        cal_start_out |-> cal_steps_out == (cal_sel_out == CAL_FULL ? STEPS_FULL
        : cal_sel_out == CAL_GAIN_OFFS ? STEPS_GAIN_OFFS
        : cal_sel_out == CAL_OFFS_ONLY ? STEPS_OFFS : STEPS_GAIN))
        else $error("calibration steps wrong");
    a_coef_decode: assert property (
        !cal_start_out |-> coef_sel_out == 4'h1 << cal_sel_out && cal_steps_out == 3'h0)
        else $error("coefficient select wrong");
    a_idle_stable: assert property (
        idle_cnt == 4'hF |-> $stable({input_arrangement_sel_out, chan_sel_out,
        power_mgmt_out, read_sel_out, cal_sel_out})) else $error("word moved while idle");
    a_test_no_ctrl: assert property (
        test_write_out |-> !conv_start_pulse_out && !cal_start_pulse_out)
        else $error("test frame started work");
endmodule : acwd_decoder_chk
bind acwd_decoder acwd_decoder_chk chk_u (.*);
`default_nettype wire

// ### testbench/acwd_host_model.sv
// host serial master writing frames to the decoder
`default_nettype none
module acwd_host_model (
    // serial link towards the device
    output var logic sclk_out,
    output var logic frame_n_out,
    output var logic din_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock idles high and stands still between frames
    initial begin
        sclk_out = 1'b1;
        frame_n_out = 1'b1;
        din_out = 1'b0;
    end
    ////////////////////////////////////////
    // nbits below 16 cuts a frame short, above 16 adds clocks, both on purpose
    task automatic send(input logic [15:0] frm, input int nbits);
        frame_n_out = 1'b0;
        #160;
        for (int i = 0; i < nbits; i++) begin
            din_out = frm[15 - (i % 16)];
            #80 sclk_out = 1'b0;
            #80 sclk_out = 1'b1;
        end
        // released line shows the inverse, not a stale bit
        din_out = ~din_out;
        #160 frame_n_out = 1'b1;
        #1000;
    endtask : send
endmodule : acwd_host_model
`default_nettype wire

// ### testbench/tb_acwd_decoder.sv
// self-checking bench for the converter control word decoder
`default_nettype none
module tb_acwd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import acwd_pkg::*;
    logic sys_clk_in, rst_n_in, link_sclk_in, link_frame_n_in, link_din_in;
    logic conv_done_in, cal_done_in, input_arrangement_sel_out, iface_mode1_out;
    logic soft_convert_start_out, conv_start_pulse_out, cal_family_sel_out;
    logic cal_start_out, cal_start_pulse_out, test_write_out, calib_write_out;
    logic [1:0] power_mgmt_out, read_sel_out, cal_sel_out;
    logic [2:0] chan_sel_out, cal_steps_out;
    logic [3:0] pos_input_out, neg_input_out, read_src_out, coef_sel_out;
    logic [DATA_BITS-1:0] write_data_out, w, wd;
    logic m;
    logic [62:0] obs;
    logic [62:0] q [$];
    logic [15:0] pc, epc;
    int n_mismatch, n_tests;
    int seed = 32'h04BE7668;
    assign obs = {pc, input_arrangement_sel_out, chan_sel_out, pos_input_out, neg_input_out,
        power_mgmt_out, read_sel_out, read_src_out, iface_mode1_out, soft_convert_start_out,
        cal_family_sel_out, cal_sel_out, cal_start_out, cal_steps_out, coef_sel_out,
        write_data_out};
    acwd_host_model host_u (
        .sclk_out    (link_sclk_in),
        .frame_n_out (link_frame_n_in),
        .din_out     (link_din_in)
    );
    acwd_decoder dut_u (.*);
    // strobe counters, one nibble each {test, calib, conv, cal}
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pc <= 16'h0000;
        end else begin
            pc <= pc + {3'h0, test_write_out, 3'h0, calib_write_out, 3'h0,
                        conv_start_pulse_out, 3'h0, cal_start_pulse_out};
        end
    end
    ////////////////////////////////////////
    function automatic logic [46:0] expv(input logic [13:0] v, input logic md,
                                         input logic [13:0] d);
        logic [3:0] p;
        logic [2:0] s [4];
        s = '{STEPS_FULL, STEPS_GAIN_OFFS, STEPS_OFFS, STEPS_GAIN};
        p = {1'b0, v[11:10], 1'b0} + 4'h1 + {3'h0, v[12]};
        return {v[13:10], p, v[13] ? INPUT_GROUND : (v[12] ? p - 4'h1 : p + 4'h1), v[9:6],
            4'h1 << v[7:6], md, v[4:0], v[0] ? s[v[2:1]] : 3'h0,
            v[0] ? 4'h0 : 4'h1 << v[2:1], d};
    endfunction : expv
    task automatic check(input logic [62:0] seen, input logic [62:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    // the note is queued before the frame, the monitor takes it after
    task automatic wr(input logic [1:0] a, input logic [13:0] d, input int nb);
        if (nb >= FRAME_BITS && a != ADDR_NONE) wd = d;
        m = 1'b0;
        if (nb >= FRAME_BITS && a == ADDR_CONTROL) begin
            w = d;
            m = d[BIT_IF_MODE];
        end
        if (nb >= FRAME_BITS) begin
            epc += {3'h0, a == ADDR_TEST, 3'h0, a == ADDR_CALIB, 3'h0,
                    a == ADDR_CONTROL && d[BIT_CONV_START], 3'h0,
                    a == ADDR_CONTROL && d[BIT_CAL_START]};
        end
        q.push_back({epc, expv(w, m, wd)});
        host_u.send({a, d}, nb);
    endtask : wr
    task automatic done(input logic cal);
        @(negedge sys_clk_in);
        if (cal) w[BIT_CAL_START] = 1'b0;
        else w[BIT_CONV_START] = 1'b0;
        q.push_back({epc, expv(w, m, wd)});
        cal_done_in = cal;
        conv_done_in = !cal;
        @(negedge sys_clk_in);
        cal_done_in = 1'b0;
        conv_done_in = 1'b0;
        repeat (8) @(negedge sys_clk_in);
    endtask : done
    ////////////////////////////////////////
    always @(posedge link_frame_n_in or posedge conv_done_in or posedge cal_done_in) begin
        repeat (6) @(posedge sys_clk_in);
        #1;
        if (q.size() > 0) check(obs, q.pop_front());
    end
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        logic [13:0] d;
        rst_n_in = 1'b0;
        conv_done_in = 1'b0;
        cal_done_in = 1'b0;
        w = CTRL_RESET;
        wd = 14'h0000;
        m = 1'b0;
        epc = 16'h0000;
        // two edges suffice: the synchronisers reset with everything else
        repeat (2) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        repeat (10) @(negedge sys_clk_in);
        wr(ADDR_NONE, 14'($random(seed)), FRAME_BITS);
        $display("test power-up done");
        for (int i = 0; i < 16; i++) begin
            d = 14'($random(seed));
            d[13:6] = {i[3:0], i[3:0]};
            d[BIT_CONV_START] = 1'b0;
            d[BIT_CAL_START] = 1'b0;
            d[BIT_IF_MODE] = 1'b1;
            wr(ADDR_CONTROL, d, FRAME_BITS);
        end
        $display("test channels done");
        wr(ADDR_TEST, 14'($random(seed)), FRAME_BITS);
        wr(ADDR_CALIB, 14'($random(seed)), FRAME_BITS);
        wr(ADDR_CONTROL, 14'($random(seed)), FRAME_BITS + 2);
        wr(ADDR_CONTROL, 14'($random(seed)), 12);
        $display("test other targets done");
        for (int i = 0; i < 9; i++) begin
            d = 14'($random(seed));
            d[4:0] = (i == 8) ? 5'h10 : {1'b0, i[2:0], 1'b1};
            wr(ADDR_CONTROL, d, FRAME_BITS);
            done(i != 8);
        end
        $display("test start bits done");
        // reset in mid-run must bring the word and the strobes back to power-up
        rst_n_in = 1'b0;
        w = CTRL_RESET;
        wd = 14'h0000;
        epc = 16'h0000;
        repeat (2) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        wr(ADDR_NONE, 14'($random(seed)), FRAME_BITS);
        $display("test mid-run reset done");
        // a note left unchecked means a result never appeared
        if (q.size() > 0) n_mismatch++;
        stop_test();
    end
endmodule : tb_acwd_decoder
`default_nettype wire
